/* File: tb/rtcc_host_model.sv */
// Serial bus master model, 4-wire and 3-wire, sclk idles high
`timescale 1ns/1ps
`default_nettype none

module rtcc_host_model (
  input  wire logic clk,
  input  wire logic mode_3w,
  input  wire logic miso,
  output logic      cs_n,
  output logic      ce,
  output logic      sclk,
  output logic      din,
  output logic      host_io,
  output logic      host_io_en
);
  initial begin
    cs_n = 1'b1;
    ce = 1'b0;
    sclk = 1'b1;
    din = 1'b0;
    host_io = 1'b0;
    host_io_en = 1'b0;
  end

  // Half bit of 80 ns, always launched just after a clk edge
  task automatic step();
    repeat (20) @(posedge clk);
    #1;
  endtask : step

  // Bytes 1..n come from and land in wd/rd, lowest byte first
  task automatic frame(input logic [7:0] adr, input int n,
                       input logic [31:0] wd, output logic [31:0] rd);
    logic [7:0] b;
    rd = 32'h0000_0000;
    cs_n = mode_3w;
    ce = mode_3w;
    step();
    for (int i = 0; i <= n; i++) begin
      b = (i == 0) ? adr : wd[8*(i-1) +: 8];
      for (int k = 7; k >= 0; k--) begin
        sclk = 1'b0;
        din = b[k];
        host_io = b[k];
        host_io_en = (i == 0) || adr[7];
        step();
        sclk = 1'b1;
        if (i > 0)
          rd[8*(i-1)+k] = miso;
        step();
      end
    end
    cs_n = 1'b1;
    ce = 1'b0;
    host_io_en = 1'b0;
    din = ~din;
    step();
  endtask : frame
endmodule : rtcc_host_model

`default_nettype wire

/* File: tb/rtcc_props.sv */
// Port checker for the serial calendar clock core
`timescale 1ns/1ps
`default_nettype none

module rtcc_props
  import rtcc_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       mode_3w,
  input wire logic       cs_n,
  input wire logic       ce,
  input wire logic       supply_ok,
  input wire logic       rst_out_n,
  input wire logic       dout_oe_n,
  input wire logic       io_oe_n,
  input wire logic       wave_or_irq_out,
  input wire logic       wave_or_irq_oe_n,
  input wire logic [7:0] trickle_cfg
);
  // ==========================================================================
  // Helper: cycles of unbroken good supply
  logic [9:0] ok_cnt;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      ok_cnt <= 10'h000;
    else if (!supply_ok)
      ok_cnt <= 10'h000;
    else if (ok_cnt != 10'h3ff)
      ok_cnt <= ok_cnt + 10'h001;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================================
  // Properties
  property p_dout_idle;
    (cs_n || mode_3w) [*5] |-> dout_oe_n;
  endproperty
  a_dout_idle: assert property (p_dout_idle)
    else $error("dout driven while not selected");

  property p_io_idle;
    (!ce || !mode_3w) [*5] |-> io_oe_n;
  endproperty
  a_io_idle: assert property (p_io_idle)
    else $error("io driven while not selected");

  property p_gate_drive;
    !rst_out_n |=> dout_oe_n && io_oe_n;
  endproperty
  a_gate_drive: assert property (p_gate_drive)
    else $error("data pin driven while supply reset low");

  property p_rst_fail;
    !supply_ok [*4] |-> !rst_out_n;
  endproperty
  a_rst_fail: assert property (p_rst_fail)
    else $error("reset out high while supply bad");

  property p_rst_hold;
    $rose(rst_out_n) |-> ok_cnt >= RST_HOLD_CYC;
  endproperty
  a_rst_hold: assert property (p_rst_hold)
    else $error("reset out released too early");

  property p_rst_cause;
    $fell(rst_out_n) |->
      !($past(supply_ok) && $past(supply_ok, 2) && $past(supply_ok, 3));
  endproperty
  a_rst_cause: assert property (p_rst_cause)
    else $error("reset out fell without supply failure");

  property p_trickle_wr;
    $changed(trickle_cfg) |-> rst_out_n && (mode_3w ? ce : !cs_n);
  endproperty
  a_trickle_wr: assert property (p_trickle_wr)
    else $error("trickle changed outside a selected frame");

  property p_od_value;
    !wave_or_irq_oe_n |-> !wave_or_irq_out;
  endproperty
  a_od_value: assert property (p_od_value)
    else $error("open drain pin driven high");

  c_rst_rise: cover property ($rose(rst_out_n));
  c_dout_read: cover property (!dout_oe_n);
  c_io_read: cover property (!io_oe_n);
  c_wave: cover property ($fell(wave_or_irq_oe_n));
endmodule : rtcc_props

bind rtcc_core rtcc_props rtcc_props_i (
  .clk(clk), .rst_n(rst_n), .mode_3w(mode_3w), .cs_n(cs_n), .ce(ce),
  .supply_ok(supply_ok), .rst_out_n(rst_out_n), .dout_oe_n(dout_oe_n),
  .io_oe_n(io_oe_n), .wave_or_irq_out(wave_or_irq_out),
  .wave_or_irq_oe_n(wave_or_irq_oe_n), .trickle_cfg(trickle_cfg)
);

`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the serial calendar clock core
`timescale 1ns/1ps
`default_nettype none

module tb;
  import rtcc_pkg::*;
  logic        clk, rst_n, en, mode_3w, cs_n, ce, sclk, din, osc_32k;
  logic        supply_ok, host_io, host_io_en, io_wire, miso, prev;
  logic        dout, dout_oe_n, io_out, io_oe_n, rst_out_n;
  logic        wave_or_irq_out, wave_or_irq_oe_n, alarm_flag;
  logic [7:0]  trickle_cfg;
  logic [31:0] rd;
  int          errors, n_checks, t;

  // Undriven lines follow sclk so a stale level never reads as data
  assign io_wire = !io_oe_n ? io_out : (host_io_en ? host_io : sclk);
  assign miso = mode_3w ? io_wire : (dout_oe_n ? sclk : dout);

  rtcc_core rtcc_core_i (
    .clk(clk), .rst_n(rst_n), .en(en), .mode_3w(mode_3w), .cs_n(cs_n),
    .ce(ce), .sclk(sclk), .din(din), .dout(dout), .dout_oe_n(dout_oe_n),
    .io_in(io_wire), .io_out(io_out), .io_oe_n(io_oe_n),
    .osc_32k(osc_32k), .supply_ok(supply_ok), .rst_out_n(rst_out_n),
    .wave_or_irq_out(wave_or_irq_out), .wave_or_irq_oe_n(wave_or_irq_oe_n),
    .alarm_flag(alarm_flag), .trickle_cfg(trickle_cfg)
  );

  rtcc_host_model rtcc_host_model_i (
    .clk(clk), .mode_3w(mode_3w), .miso(miso), .cs_n(cs_n), .ce(ce),
    .sclk(sclk), .din(din), .host_io(host_io), .host_io_en(host_io_en)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    osc_32k = 1'b0;
    forever #15259 osc_32k = ~osc_32k;
  end

  // ==========================================================================
  // Tasks
  task automatic chk(input string what, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input int n, input logic [31:0] d);
    rtcc_host_model_i.frame(a | 8'h80, n, d, rd);
  endtask : wr

  task automatic rdr(input logic [7:0] a, input int n);
    rtcc_host_model_i.frame(a, n, 32'h0000_0000, rd);
  endtask : rdr

  task automatic wait_rst_out(output int c);
    c = 0;
    while (rst_out_n !== 1'b1 && c < 400) begin
      @(posedge clk);
      #1;
      c++;
    end
  endtask : wait_rst_out

  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  // Whole run is near 72k clocks
  initial begin
    repeat (90000) @(posedge clk);
    errors++;
    final_report();
  end

  // ==========================================================================
  // Tests
  initial begin
    errors = 0;
    n_checks = 0;
    rst_n = 1'b0;
    en = 1'b1;
    mode_3w = 1'b0;
    supply_ok = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("rst_out_n in reset", rst_out_n, 0);
    chk("trickle in reset", trickle_cfg, TRKL_RST);
    chk("alarm in reset", alarm_flag, 0);
    chk("oe in reset", {dout_oe_n, io_oe_n, wave_or_irq_oe_n}, 3'b111);
    rst_n = 1'b1;
    wait_rst_out(t);
    chk("release delay", t >= RST_HOLD_CYC, 1);
    wr(8'h0F, 1, 32'h0000_00A5);
    chk("trickle write", trickle_cfg, 8'hA5);
    wr(8'h0F, 2, 32'h0000_123C);
    chk("trickle multi", trickle_cfg, 8'h3C);
    rdr(8'h0F, 3);
    chk("read wrap", rd, 32'h0000_123C);
    rdr(8'h05, 2);
    chk("date month", rd, 32'h0000_0101);
    supply_ok = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    chk("rst_out_n on fail", rst_out_n, 0);
    wr(8'h0F, 1, 32'h0000_0055);
    chk("write blocked", trickle_cfg, 8'h3C);
    supply_ok = 1'b1;
    wr(8'h0F, 1, 32'h0000_0066);
    chk("early frame", trickle_cfg, 8'h3C);
    wait_rst_out(t);
    wr(8'h0F, 1, 32'h0000_0077);
    chk("write restored", trickle_cfg, 8'h77);
    en = 1'b0;
    wr(8'h0F, 1, 32'h0000_0099);
    en = 1'b1;
    chk("frozen by enable", trickle_cfg, 8'h77);
    mode_3w = 1'b1;
    wr(8'h0F, 1, 32'h0000_005A);
    rdr(8'h0F, 1);
    chk("3-wire trickle", rd, 32'h0000_005A);
    mode_3w = 1'b0;
    for (int r = 0; r < 3; r++) begin
      wr(ADR_CTRL, 1, 32'(8'h04 | (r << CTRL_RATE_LSB)));
      t = 0;
      prev = wave_or_irq_oe_n;
      // Two oscillator periods, four for the slowest rate tried here
      repeat ((r == 2) ? 30518 : 15259) begin
        @(posedge clk);
        #1;
        if (wave_or_irq_oe_n !== prev)
          t++;
        prev = wave_or_irq_oe_n;
      end
      chk("wave toggles", t, (r == 0) ? 4 : 1);
    end
    wr(ADR_CTRL, 1, 32'h0000_0000);
    repeat (20) @(posedge clk);
    #1;
    chk("pin idle", wave_or_irq_oe_n, 1);
    final_report();
  end
endmodule : tb

`default_nettype wire

/* File: verilog/rtcc_calendar.sv */
// BCD calendar counters with write port and tick-driven cascade
`timescale 1ns/1ps
`default_nettype none

module rtcc_calendar
  import rtcc_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic            en,
  input  wire logic            tick,
  input  wire logic            wr_en,
  input  wire logic [2:0]      wr_addr,
  input  wire logic [7:0]      wr_data,
  output logic      [7:0][7:0] time_regs
);

  typedef struct packed {
    logic [7:0][7:0] t;
  } rtcc_cal_s;

  rtcc_cal_s  q;
  rtcc_cal_s  next_q;
  logic [8:0] r;
  logic [7:0] hr;
  logic       pm;
  logic       day_carry;

  // ==========================================================================
  // Helpers
  function automatic logic [8:0] bcd_step(input logic [7:0] v,
                                          input logic [7:0] last,
                                          input logic [7:0] first);
    if (v == last) begin
      return {1'b1, first};
    end else if (v[3:0] == 4'h9) begin
      return {1'b0, v[7:4] + 4'h1, 4'h0};
    end else begin
      return {1'b0, v[7:4], v[3:0] + 4'h1};
    end
  endfunction : bcd_step

  function automatic logic [7:0] month_last(input logic [4:0] m,
                                            input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    case (m)
      5'h02:   return leap ? 8'h29 : 8'h28;
      5'h04,
      5'h06,
      5'h09,
      5'h11:   return 8'h30;
      default: return 8'h31;
    endcase
  endfunction : month_last

  // ==========================================================================
  // Cascade
  always_comb begin
    next_q    = q;
    r         = '0;
    hr        = '0;
    pm        = 1'b0;
    day_carry = 1'b0;
    if (tick) begin
      r = bcd_step(q.t[TI_HSEC], 8'h99, 8'h00);
      next_q.t[TI_HSEC] = r[7:0];
      if (r[8]) begin
        r = bcd_step({1'b0, q.t[TI_SEC][6:0]}, 8'h59, 8'h00);
        next_q.t[TI_SEC] = r[7:0];
        if (r[8]) begin
          r = bcd_step({1'b0, q.t[TI_MIN][6:0]}, 8'h59, 8'h00);
          next_q.t[TI_MIN] = r[7:0];
          if (r[8]) begin
            if (q.t[TI_HOUR][HOUR_12_BIT]) begin
              hr = {3'b000, q.t[TI_HOUR][4:0]};
              pm = q.t[TI_HOUR][HOUR_PM_BIT];
              if (hr == 8'h11) begin
                next_q.t[TI_HOUR] = {2'b01, ~pm, 5'h12};
                day_carry = pm;
              end else if (hr == 8'h12) begin
                next_q.t[TI_HOUR] = {2'b01, pm, 5'h01};
              end else begin
                r = bcd_step(hr, 8'h12, 8'h01);
                next_q.t[TI_HOUR] = {2'b01, pm, r[4:0]};
              end
            end else begin
              r = bcd_step({2'b00, q.t[TI_HOUR][5:0]}, 8'h23, 8'h00);
              next_q.t[TI_HOUR] = r[7:0];
              day_carry = r[8];
            end
            if (day_carry) begin
              r = bcd_step({5'h00, q.t[TI_DAY][2:0]}, 8'h07, 8'h01);
              next_q.t[TI_DAY] = r[7:0];
              r = bcd_step({2'b00, q.t[TI_DATE][5:0]},
                           month_last(q.t[TI_MONTH][4:0], q.t[TI_YEAR]),
                           8'h01);
              next_q.t[TI_DATE] = r[7:0];
              if (r[8]) begin
                r = bcd_step({3'b000, q.t[TI_MONTH][4:0]}, 8'h12, 8'h01);
                next_q.t[TI_MONTH] = {q.t[TI_MONTH][CENTURY_BIT], 2'b00,
                                      r[4:0]};
                if (r[8]) begin
                  r = bcd_step(q.t[TI_YEAR], 8'h99, 8'h00);
                  next_q.t[TI_YEAR] = r[7:0];
                  next_q.t[TI_MONTH][CENTURY_BIT] =
                    q.t[TI_MONTH][CENTURY_BIT] ^ r[8];
                end
              end
            end
          end
        end
      end
    end
    // A host write lands on that byte only; the rest keeps cascading
    if (wr_en) begin
      next_q.t[wr_addr] = wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q.t <= TIME_RST;
    end else if (en) begin
      q <= next_q;
    end
  end

  assign time_regs = q.t;

endmodule : rtcc_calendar

`default_nettype wire

/* File: verilog/rtcc_core.sv */
// Serial calendar clock core: serial slave, alarm, wave output, supply gate
// ============================================================================
`timescale 1ns/1ps
`default_nettype none

module rtcc_core
  import rtcc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       en,
  input  wire logic       mode_3w,
  input  wire logic       cs_n,
  input  wire logic       ce,
  input  wire logic       sclk,
  input  wire logic       din,
  output logic            dout,
  output logic            dout_oe_n,
  input  wire logic       io_in,
  output logic            io_out,
  output logic            io_oe_n,
  input  wire logic       osc_32k,
  input  wire logic       supply_ok,
  output logic            rst_out_n,
  output logic            wave_or_irq_out,
  output logic            wave_or_irq_oe_n,
  output logic            alarm_flag,
  output logic      [7:0] trickle_cfg
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic                 osc_a;
    logic                 osc_b;
    logic                 osc_c;
    logic                 sclk_a;
    logic                 sclk_b;
    logic                 sclk_c;
    logic                 cs_a;
    logic                 cs_b;
    logic                 ce_a;
    logic                 ce_b;
    logic                 din_a;
    logic                 din_b;
    logic                 io_a;
    logic                 io_b;
    logic                 sup_a;
    logic                 sup_b;
    logic                 sel_d;
    logic [ACC_W-1:0]     acc;
    logic [DIV_W-1:0]     div;
    logic                 tick;
    logic                 tick_d;
    rtcc_ser_e            ser;
    logic [2:0]           bitcnt;
    logic [7:0]           shin;
    logic [7:0]           shout;
    logic [3:0]           ptr;
    logic                 is_wr;
    logic [7:0][7:0]      shadow;
    logic [4:0][7:0]      alarm;
    logic [7:0]           ctrl;
    logic [7:0]           stat;
    logic [7:0]           trkl;
    logic [RST_CNT_W-1:0] rst_cnt;
    logic                 rst_rel;
    logic                 cal_wr;
    logic [2:0]           cal_addr;
    logic [7:0]           cal_data;
    logic                 dout;
    logic                 dout_oe_n;
    logic                 io_out;
    logic                 io_oe_n;
    logic                 wave_lvl_out;
    logic                 wave_oe_n;
  } rtcc_core_s;

  rtcc_core_s      q;
  rtcc_core_s      next_q;
  logic [7:0][7:0] time_regs;
  logic [4:0]      match;
  logic            osc_rise;
  logic            sclk_rise;
  logic            sclk_fall;
  logic            sel;
  logic            din_v;
  logic            wave_lvl;
  logic [7:0]      byte_in;
  logic [ACC_W-1:0] acc_sum;

  // ==========================================================================
  // Register access helpers
  function automatic logic [7:0] rd_byte(input rtcc_core_s s,
                                         input logic [3:0] a);
    if (!a[3]) begin
      return s.shadow[a[2:0]];
    end else if (a == ADR_CTRL) begin
      return s.ctrl;
    end else if (a == ADR_STAT) begin
      return s.stat & STAT_MASK;
    end else if (a == ADR_TRKL) begin
      return s.trkl;
    end else begin
      return s.alarm[a[2:0]];
    end
  endfunction : rd_byte

  // ==========================================================================
  // Calendar
  rtcc_calendar u_calendar (
    .clk       (clk),
    .rst_n     (rst_n),
    .en        (en),
    .tick      (q.tick),
    .wr_en     (q.cal_wr),
    .wr_addr   (q.cal_addr),
    .wr_data   (q.cal_data),
    .time_regs (time_regs)
  );

  // ==========================================================================
  // Alarm match, one comparator per alarm byte
  genvar gi;
  for (gi = 0; gi < 5; gi++) begin : g_alm
    localparam logic [2:0] TIDX = (gi == 4) ? TI_DATE : 3'(gi);
    localparam logic [7:0] CMP  = (gi == 0) ? ALM_FULL_MASK : ALM_VAL_MASK;
    assign match[gi] = ((gi != 0) && q.alarm[gi][ALM_MASK_BIT]) ||
                       (((q.alarm[gi] ^ time_regs[TIDX]) & CMP) == 8'h00);
  end

  // ==========================================================================
  // Next state
  always_comb begin
    next_q    = q;
    byte_in   = 8'h00;
    wave_lvl  = 1'b0;
    acc_sum   = q.acc + ACC_STEP;
    osc_rise  = q.osc_b & ~q.osc_c;
    sclk_rise = q.sclk_b & ~q.sclk_c;
    sclk_fall = ~q.sclk_b & q.sclk_c;
    sel       = mode_3w ? q.ce_b : ~q.cs_b;
    din_v     = mode_3w ? q.io_b : q.din_b;

    // Pin synchronisers
    next_q.osc_a  = osc_32k;
    next_q.osc_b  = q.osc_a;
    next_q.osc_c  = q.osc_b;
    next_q.sclk_a = sclk;
    next_q.sclk_b = q.sclk_a;
    next_q.sclk_c = q.sclk_b;
    next_q.cs_a   = cs_n;
    next_q.cs_b   = q.cs_a;
    next_q.ce_a   = ce;
    next_q.ce_b   = q.ce_a;
    next_q.din_a  = din;
    next_q.din_b  = q.din_a;
    next_q.io_a   = io_in;
    next_q.io_b   = q.io_a;
    next_q.sup_a  = supply_ok;
    next_q.sup_b  = q.sup_a;

    // Hundredths tick: 100 ticks per 32768 oscillator edges, exactly
    next_q.tick   = 1'b0;
    next_q.tick_d = q.tick;
    if (osc_rise) begin
      next_q.div = q.div + 1'b1;
      if (acc_sum >= ACC_WRAP) begin
        next_q.acc  = acc_sum - ACC_WRAP;
        next_q.tick = 1'b1;
      end else begin
        next_q.acc = acc_sum;
      end
    end

    // Supply monitor reset with hold-off after recovery
    if (!q.sup_b) begin
      next_q.rst_rel = 1'b0;
      next_q.rst_cnt = '0;
    end else if (!q.rst_rel) begin
      if (q.rst_cnt == RST_HOLD_LAST) begin
        next_q.rst_rel = 1'b1;
      end else begin
        next_q.rst_cnt = q.rst_cnt + 1'b1;
      end
    end

    // Serial slave: it only ever answers the host's clock
    next_q.sel_d  = sel;
    next_q.cal_wr = 1'b0;
    if (!sel) begin
      next_q.ser       = SER_IDLE;
      next_q.dout_oe_n = 1'b1;
      next_q.io_oe_n   = 1'b1;
    end else if (!q.sel_d) begin
      next_q.shadow = time_regs;
      next_q.bitcnt = 3'h0;
      next_q.ser    = q.rst_rel ? SER_ADDR : SER_DEAD;
    end else if (!q.rst_rel) begin
      // A supply drop mid-frame kills the rest of the frame
      next_q.ser       = SER_DEAD;
      next_q.dout_oe_n = 1'b1;
      next_q.io_oe_n   = 1'b1;
    end else if (q.ser == SER_ADDR || q.ser == SER_DATA) begin
      if (sclk_rise) begin
        next_q.shin   = {q.shin[6:0], din_v};
        next_q.bitcnt = q.bitcnt + 3'h1;
        if (q.bitcnt == 3'h7) begin
          byte_in = {q.shin[6:0], din_v};
          if (q.ser == SER_ADDR) begin
            next_q.ser   = SER_DATA;
            next_q.is_wr = byte_in[CMD_WRITE_BIT];
            if (byte_in[CMD_WRITE_BIT]) begin
              next_q.ptr = byte_in[3:0];
            end else begin
              next_q.shout = rd_byte(q, byte_in[3:0]);
              next_q.ptr   = byte_in[3:0] + PTR_STEP;
            end
          end else begin
            next_q.ptr = q.ptr + PTR_STEP;
            if (q.is_wr) begin
              if (!q.ptr[3]) begin
                next_q.cal_wr   = 1'b1;
                next_q.cal_addr = q.ptr[2:0];
                next_q.cal_data = byte_in;
              end else if (q.ptr == ADR_CTRL) begin
                next_q.ctrl = byte_in;
              end else if (q.ptr == ADR_STAT) begin
                next_q.stat = q.stat & byte_in & STAT_MASK;
              end else if (q.ptr == ADR_TRKL) begin
                next_q.trkl = byte_in;
              end else begin
                next_q.alarm[q.ptr[2:0]] = byte_in;
              end
            end else begin
              next_q.shout = rd_byte(q, q.ptr);
            end
          end
        end
      end
      // Read data changes on the falling edge, host samples on rising
      if (sclk_fall && q.ser == SER_DATA && !q.is_wr) begin
        next_q.shout = {q.shout[6:0], 1'b0};
        if (mode_3w) begin
          next_q.io_out  = q.shout[7];
          next_q.io_oe_n = 1'b0;
        end else begin
          next_q.dout      = q.shout[7];
          next_q.dout_oe_n = 1'b0;
        end
      end
    end

    // Alarm flag: a match beats a same-cycle clear by the host
    if (q.tick_d && (&match)) begin
      next_q.stat[STAT_ALM_BIT] = 1'b1;
    end

    // Combined pin: wave when enabled, else active-low interrupt
    case (rtcc_rate_e'(q.ctrl[CTRL_RATE_LSB +: 2]))
      RATE_32K: wave_lvl = q.osc_b;
      RATE_8K:  wave_lvl = q.div[DIV_8K_BIT];
      RATE_4K:  wave_lvl = q.div[DIV_4K_BIT];
      RATE_1HZ: wave_lvl = q.div[DIV_1HZ_BIT];
      default:  wave_lvl = 1'b0;
    endcase
    // Nothing here looks at supply state, so it keeps going on backup
    if (q.ctrl[CTRL_WAVE_EN]) begin
      next_q.wave_oe_n = wave_lvl;
    end else begin
      next_q.wave_oe_n = ~(q.stat[STAT_ALM_BIT] & q.ctrl[CTRL_IRQ_EN]);
    end
    next_q.wave_lvl_out = 1'b0;
  end

  // ==========================================================================
  // Registers; no supply input touches them, so contents ride on backup
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q           <= '0;
      // Pin copies start at idle levels so reset shows no false edge
      q.sclk_a    <= 1'b1;
      q.sclk_b    <= 1'b1;
      q.sclk_c    <= 1'b1;
      q.cs_a      <= 1'b1;
      q.cs_b      <= 1'b1;
      q.ser       <= SER_IDLE;
      q.ctrl      <= CTRL_RST;
      q.trkl      <= TRKL_RST;
      q.dout_oe_n <= 1'b1;
      q.io_oe_n   <= 1'b1;
      q.wave_oe_n <= 1'b1;
    end else if (en) begin
      q <= next_q;
    end
  end

  // ==========================================================================
  // Outputs
  assign dout             = q.dout;
  assign dout_oe_n        = q.dout_oe_n;
  assign io_out           = q.io_out;
  assign io_oe_n          = q.io_oe_n;
  assign rst_out_n        = q.rst_rel;
  assign wave_or_irq_out  = q.wave_lvl_out;
  assign wave_or_irq_oe_n = q.wave_oe_n;
  assign alarm_flag       = q.stat[STAT_ALM_BIT];
  assign trickle_cfg      = q.trkl;

endmodule : rtcc_core

`default_nettype wire

/* File: verilog/rtcc_pkg.sv */
// Constants and types shared by the serial calendar clock core
package rtcc_pkg;

  // ==========================================================================
  // Register map (4-bit register pointer)
  localparam int          CMD_WRITE_BIT  = 7;
  localparam logic [3:0]  ADR_ALM_HSEC   = 4'h8;
  localparam logic [3:0]  ADR_ALM_DATE   = 4'hC;
  localparam logic [3:0]  ADR_CTRL       = 4'hD;
  localparam logic [3:0]  ADR_STAT       = 4'hE;
  localparam logic [3:0]  ADR_TRKL       = 4'hF;
  localparam logic [3:0]  PTR_STEP       = 4'h1;

  // Calendar byte index inside the time block
  localparam logic [2:0]  TI_HSEC        = 3'h0;
  localparam logic [2:0]  TI_SEC         = 3'h1;
  localparam logic [2:0]  TI_MIN         = 3'h2;
  localparam logic [2:0]  TI_HOUR        = 3'h3;
  localparam logic [2:0]  TI_DAY         = 3'h4;
  localparam logic [2:0]  TI_DATE        = 3'h5;
  localparam logic [2:0]  TI_MONTH       = 3'h6;
  localparam logic [2:0]  TI_YEAR        = 3'h7;

  // ==========================================================================
  // Field positions
  localparam int          HOUR_12_BIT    = 6;
  localparam int          HOUR_PM_BIT    = 5;
  localparam int          CENTURY_BIT    = 7;
  localparam int          ALM_MASK_BIT   = 7;
  localparam int          CTRL_IRQ_EN    = 0;
  localparam int          CTRL_WAVE_EN   = 2;
  localparam int          CTRL_RATE_LSB  = 3;
  localparam int          STAT_ALM_BIT   = 0;
  localparam logic [7:0]  STAT_MASK      = 8'h01;
  localparam logic [7:0]  ALM_FULL_MASK  = 8'hFF;
  localparam logic [7:0]  ALM_VAL_MASK   = 8'h7F;

  // ==========================================================================
  // Values after reset
  localparam logic [63:0] TIME_RST       = 64'h0001_0101_0000_0000;
  localparam logic [7:0]  CTRL_RST       = 8'h00;
  localparam logic [7:0]  TRKL_RST       = 8'h00;

  // ==========================================================================
  // Timing
  localparam int          OSC_HZ         = 32768;
  localparam int          TICK_HZ        = 100;
  localparam int          ACC_W          = 16;
  localparam logic [15:0] ACC_STEP       = 16'(TICK_HZ);
  localparam logic [15:0] ACC_WRAP       = 16'(OSC_HZ);
  localparam int          DIV_W          = 15;
  localparam int          DIV_8K_BIT     = 1;
  localparam int          DIV_4K_BIT     = 2;
  localparam int          DIV_1HZ_BIT    = 14;
  localparam int          CLK_PERIOD_NS  = 4;
  localparam int          RST_HOLD_NS    = 1000;
  localparam int          RST_HOLD_CYC   =
    (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          RST_CNT_W      = 16;
  localparam logic [15:0] RST_HOLD_LAST  = 16'(RST_HOLD_CYC - 1);

  // ==========================================================================
  // Enumerations
  typedef enum logic [1:0] {
    RATE_32K = 2'b00,
    RATE_8K  = 2'b01,
    RATE_4K  = 2'b10,
    RATE_1HZ = 2'b11
  } rtcc_rate_e;

  typedef enum logic [1:0] {
    SER_IDLE = 2'b00,
    SER_ADDR = 2'b01,
    SER_DATA = 2'b11,
    SER_DEAD = 2'b10
  } rtcc_ser_e;

endpackage : rtcc_pkg
